// ==== hdl/ncoc_regs.vh ====
`ifndef NCOC_REGS_VH
`define NCOC_REGS_VH
// register offsets
`define NCOC_OSC_CTRL_ADDR   9'h11d
`define NCOC_TUNE_B0_ADDR    9'h11e
`define NCOC_TUNE_B1_ADDR    9'h11f
`define NCOC_TUNE_B2_ADDR    9'h120
`define NCOC_TUNE_B3_ADDR    9'h121
`define NCOC_PHASE_LO_ADDR   9'h122
`define NCOC_PHASE_HI_ADDR   9'h123
// control field positions
`define NCOC_CTRL_EN_BIT     0
`define NCOC_CTRL_ADITH_BIT  1
`define NCOC_CTRL_PDITH_BIT  2
// reset values
`define NCOC_CTRL_RST        3'h0
`define NCOC_TUNE_RST        32'h0000_0000
`define NCOC_PHASE_RST       16'h0000
`define NCOC_LFSR_SEED       16'hace1
`endif

// ==== hdl/ncoc_top.v ====
`timescale 1ns/1ns
`include "ncoc_regs.vh"

// Contract
// - control bit 2 enables phase dither
// - control bit 1 enables amplitude dither
// - bit 0 runs oscillator; clear bypasses, powers down
// - tuning word over four bytes, low first
// - tuning word is signed twos complement
// - phase offset over two bytes, low first
// - offset loads on start or sync pulse
module ncoc_top (
   // clock and reset
   input  wire        mclk,
   input  wire        rst,
   // register port
   input  wire [8:0]  reg_addr,
   input  wire        reg_wr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata_ff,
   // divided sample rate enable and sync pin
   input  wire        sample_en,
   input  wire        sync_pin,
   // incoming samples
   input  wire        in_valid,
   input  wire [13:0] in_sample,
   output reg         in_ready_ff,
   // mixed samples to the decimation filters
   output reg         out_valid_ff,
   output reg  [13:0] out_i_ff,
   output reg  [13:0] out_q_ff,
   input  wire        out_ready
);

   reg  [2:0]  ctrl_ff;
   reg  [31:0] tune_ff;
   reg  [15:0] phase_off_ff;
   reg  [31:0] acc_ff;
   reg         en_prev_ff;
   reg         sync_s1_ff;
   reg         sync_s2_ff;
   reg         sync_s3_ff;
   reg  [15:0] lfsr_ff;
   reg         skid_v_ff;
   reg  [13:0] skid_i_ff;
   reg  [13:0] skid_q_ff;

   wire        osc_en    = ctrl_ff[`NCOC_CTRL_EN_BIT];
   wire        start     = osc_en & ~en_prev_ff;
   wire        sync_evt  = sync_s2_ff & ~sync_s3_ff;
   wire        push      = in_valid & in_ready_ff & sample_en;
   wire        moving    = ~out_valid_ff | out_ready;

   // quarter-wave table, 9 points, amplitude 127
   function [7:0] ncoc_qsin;
      input [3:0] k;
      begin
         case (k)
            4'h0: ncoc_qsin = 8'h00;
            4'h1: ncoc_qsin = 8'h19;
            4'h2: ncoc_qsin = 8'h31;
            4'h3: ncoc_qsin = 8'h47;
            4'h4: ncoc_qsin = 8'h5a;
            4'h5: ncoc_qsin = 8'h6a;
            4'h6: ncoc_qsin = 8'h75;
            4'h7: ncoc_qsin = 8'h7d;
            default: ncoc_qsin = 8'h7f;
         endcase
      end
   endfunction

   // full-wave sine from a 5-bit phase index
   function [8:0] ncoc_sin;
      input [4:0] idx;
      reg   [7:0] mag;
      begin
         mag = idx[3] ? ncoc_qsin(4'h8 - {1'b0, idx[2:0]}) : ncoc_qsin({1'b0, idx[2:0]});
         ncoc_sin = idx[4] ? (9'h000 - {1'b0, mag}) : {1'b0, mag};
      end
   endfunction

   // phase dither spreads below the table index to break up spurs
   wire [15:0] ph_dith  = ctrl_ff[`NCOC_CTRL_PDITH_BIT] ?
                          {5'h00, lfsr_ff[10:0]} : 16'h0000;
   wire [15:0] ph_top   = acc_ff[31:16] + ph_dith;
   wire [4:0]  idx      = ph_top[15:11];
   // amplitude dither adds one lsb of noise to each carrier term
   wire [8:0]  amp_dith = ctrl_ff[`NCOC_CTRL_ADITH_BIT] ?
                          {8'h00, lfsr_ff[15]} : 9'h000;
   wire [8:0]  cos_v    = ncoc_sin(idx + 5'h08) + amp_dith;
   wire [8:0]  sin_v    = ncoc_sin(idx) + amp_dith;
   wire signed [22:0] prod_i = $signed(in_sample) * $signed(cos_v);
   wire signed [22:0] prod_q = $signed(in_sample) * $signed(sin_v);
   // bypass passes the sample untuned on the in-phase lane
   wire [13:0] new_i    = osc_en ? prod_i[20:7] : in_sample;
   wire [13:0] new_q    = osc_en ? 14'h0000 - prod_q[20:7] : 14'h0000;

   // register writes
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_ff      <= `NCOC_CTRL_RST;
         tune_ff      <= `NCOC_TUNE_RST;
         phase_off_ff <= `NCOC_PHASE_RST;
      end else if (reg_wr) begin
         if (reg_addr == `NCOC_OSC_CTRL_ADDR) begin
            ctrl_ff <= reg_wdata[2:0];
         end else if (reg_addr == `NCOC_TUNE_B0_ADDR) begin
            tune_ff[7:0] <= reg_wdata;
         end else if (reg_addr == `NCOC_TUNE_B1_ADDR) begin
            tune_ff[15:8] <= reg_wdata;
         end else if (reg_addr == `NCOC_TUNE_B2_ADDR) begin
            tune_ff[23:16] <= reg_wdata;
         end else if (reg_addr == `NCOC_TUNE_B3_ADDR) begin
            tune_ff[31:24] <= reg_wdata;
         end else if (reg_addr == `NCOC_PHASE_LO_ADDR) begin
            phase_off_ff[7:0] <= reg_wdata;
         end else if (reg_addr == `NCOC_PHASE_HI_ADDR) begin
            phase_off_ff[15:8] <= reg_wdata;
         end
      end
   end

   // register reads, one cycle latency, unmapped reads zero
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr == `NCOC_OSC_CTRL_ADDR) begin
            reg_rdata_ff <= {5'h00, ctrl_ff};
         end else if (reg_addr == `NCOC_TUNE_B0_ADDR) begin
            reg_rdata_ff <= tune_ff[7:0];
         end else if (reg_addr == `NCOC_TUNE_B1_ADDR) begin
            reg_rdata_ff <= tune_ff[15:8];
         end else if (reg_addr == `NCOC_TUNE_B2_ADDR) begin
            reg_rdata_ff <= tune_ff[23:16];
         end else if (reg_addr == `NCOC_TUNE_B3_ADDR) begin
            reg_rdata_ff <= tune_ff[31:24];
         end else if (reg_addr == `NCOC_PHASE_LO_ADDR) begin
            reg_rdata_ff <= phase_off_ff[7:0];
         end else if (reg_addr == `NCOC_PHASE_HI_ADDR) begin
            reg_rdata_ff <= phase_off_ff[15:8];
         end else begin
            reg_rdata_ff <= 8'h00;
         end
      end
   end

   // sync pin synchroniser; first stage feeds only the second
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         sync_s1_ff <= 1'b0;
         sync_s2_ff <= 1'b0;
         sync_s3_ff <= 1'b0;
      end else begin
         sync_s1_ff <= sync_pin;
         sync_s2_ff <= sync_s1_ff;
         sync_s3_ff <= sync_s2_ff;
      end
   end

   // phase accumulator; held still while powered down
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         acc_ff     <= 32'h0000_0000;
         en_prev_ff <= 1'b0;
      end else begin
         en_prev_ff <= osc_en;
         if (start | (osc_en & sync_evt)) begin
            acc_ff <= {phase_off_ff, 16'h0000};
         end else if (osc_en & push) begin
            acc_ff <= acc_ff + tune_ff;
         end
      end
   end

   // dither source, stepped at the sample rate only while the oscillator runs
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         lfsr_ff <= `NCOC_LFSR_SEED;
      end else if (sample_en & osc_en) begin
         lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      end
   end

   // two-entry output buffer: output stage plus skid entry
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         out_valid_ff <= 1'b0;
         out_i_ff     <= 14'h0000;
         out_q_ff     <= 14'h0000;
         skid_v_ff    <= 1'b0;
         skid_i_ff    <= 14'h0000;
         skid_q_ff    <= 14'h0000;
         in_ready_ff  <= 1'b1;
      end else begin
         // ready is registered, so the skid slot absorbs the in-flight word
         in_ready_ff <= moving | ~(skid_v_ff | push);
         if (moving) begin
            if (skid_v_ff) begin
               out_valid_ff <= 1'b1;
               out_i_ff     <= skid_i_ff;
               out_q_ff     <= skid_q_ff;
               skid_v_ff    <= 1'b0;
            end else begin
               out_valid_ff <= push;
               if (push) begin
                  out_i_ff <= new_i;
                  out_q_ff <= new_q;
               end
            end
         end else if (push) begin
            skid_v_ff <= 1'b1;
            skid_i_ff <= new_i;
            skid_q_ff <= new_q;
         end
      end
   end

endmodule // ncoc_top

// ==== sim/ncoc_chk.sv ====
`timescale 1ns/1ns
module ncoc_chk (
   // clock, reset, register port
   input wire        mclk,
   input wire        rst,
   input wire [8:0]  reg_addr,
   input wire        reg_wr,
   input wire [7:0]  reg_wdata,
   input wire        reg_rd,
   input wire [7:0]  reg_rdata_ff,
   // sample stream
   input wire        sample_en,
   input wire        in_valid,
   input wire        in_ready_ff,
   input wire        out_valid_ff,
   input wire [13:0] out_i_ff,
   input wire        out_ready
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // a sample is taken only where all three agree
   wire take = in_valid && in_ready_ff && sample_en;
   property p_hold; out_valid_ff && !out_ready |=> out_valid_ff && $stable(out_i_ff); endproperty
   a_hold: assert property (p_hold) else $error("stalled word changed");
   property p_fill; !out_valid_ff && take |=> out_valid_ff; endproperty
   a_fill: assert property (p_fill) else $error("taken word missing");
   property p_idle; !out_valid_ff && !take |=> !out_valid_ff; endproperty
   a_idle: assert property (p_idle) else $error("word from nothing");
   property p_full; !in_ready_ff |-> out_valid_ff || $past(out_valid_ff); endproperty
   a_full: assert property (p_full) else $error("refused while empty");
   property p_rsv; reg_rd && reg_addr == 9'h11d |=> reg_rdata_ff[7:3] == 5'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("control top bits set");
   property p_unmap; reg_rd && (reg_addr < 9'h11d || reg_addr > 9'h123) |=>
      reg_rdata_ff == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_keep; !reg_rd |=> $stable(reg_rdata_ff); endproperty
   a_keep: assert property (p_keep) else $error("read data moved");
   property p_back; reg_wr && reg_addr > 9'h11d && reg_addr < 9'h124 ##1 reg_rd && !reg_wr
      && reg_addr == $past(reg_addr) |=> reg_rdata_ff == $past(reg_wdata, 2); endproperty
   a_back: assert property (p_back) else $error("byte not kept");
endmodule // ncoc_chk
bind ncoc_top ncoc_chk chk_i (.*);

// ==== sim/ncoc_sink.sv ====
`timescale 1ns/1ns
module ncoc_sink (
   // clock and stall request
   input  wire        mclk,
   input  wire        stall,
   // mixed words from the block
   input  wire        out_valid_ff,
   input  wire [13:0] out_i_ff,
   input  wire [13:0] out_q_ff,
   output wire        out_ready
);
   logic [27:0] q [$];
   // plain level; a stall holds it low as long as asked
   assign out_ready = !stall;
   // a word counts only on an edge where both sides agree
   always @(posedge mclk) if (out_valid_ff && out_ready) q.push_back({out_i_ff, out_q_ff});
endmodule // ncoc_sink

// ==== sim/test_nco_tuning_control.sv ====
`timescale 1ns/1ns
module test_nco_tuning_control;
   // stimulus
   logic        mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, stall = 1;
   logic        sample_en = 0, sync_pin = 0, in_valid = 0;
   logic [8:0]  reg_addr = 0;
   logic [7:0]  reg_wdata = 0;
   logic [13:0] in_sample = 0, a, b, c, d;
   // observed
   wire [7:0]   reg_rdata_ff;
   wire         in_ready_ff, out_valid_ff, out_ready;
   wire [13:0]  out_i_ff, out_q_ff;
   int          num_errors = 0, comparisons = 0, cyc = 0, hits = 0;
   // address, write data, read back
   logic [24:0] rows [8] = '{{9'h11d, 8'hff, 8'h07}, {9'h11e, 8'h12, 8'h12},
      {9'h11f, 8'h34, 8'h34}, {9'h120, 8'h56, 8'h56}, {9'h121, 8'h87, 8'h87},
      {9'h122, 8'hab, 8'hab}, {9'h123, 8'hcd, 8'hcd}, {9'h124, 8'h5a, 8'h00}};
   ncoc_top  uut (.*);
   ncoc_sink sink (.*);
   initial forever #2 mclk = ~mclk;
   // hang guard, far above the roughly 130 cycles needed
   always @(posedge mclk) if (++cyc == 4000) begin num_errors++; final_report; end
   task chk(input logic [13:0] got, exp);
      comparisons++;
      if (got !== exp) begin num_errors++; $display("BAD %0t got %h want %h", $time, got, exp); end
   endtask
   // one register cycle; strobes stand for exactly one edge
   task acc(input logic [8:0] ad, input logic [7:0] dt, input logic w, r);
      @(negedge mclk) {reg_addr, reg_wdata, reg_wr, reg_rd} = {ad, dt, w, r};
   endtask
   task wr(input logic [8:0] ad, input logic [7:0] dt); acc(ad, dt, 1, 0); acc(ad, dt, 0, 0); endtask
   task rd(input logic [8:0] ad, input logic [7:0] ex);
      acc(ad, 0, 0, 1); acc(ad, 0, 0, 0); chk({6'h0, reg_rdata_ff}, {6'h0, ex});
   endtask
   // valid is held until a negedge sees ready, so the next edge takes it
   task send(input logic [13:0] s);
      @(negedge mclk); while (in_ready_ff !== 1'b1) @(negedge mclk);
      {in_sample, in_valid, sample_en} = {s, 2'b11};
   endtask
   task idle; @(negedge mclk) {in_valid, sample_en} = 2'b00; endtask
   task pop(output logic [13:0] i, q);
      repeat (40) if (sink.q.size() == 0) @(negedge mclk);
      {i, q} = sink.q.pop_front();
   endtask
   task final_report;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge mclk);
      rst = 0;
      foreach (rows[k]) begin
         acc(rows[k][24:16], rows[k][15:8], 1, 0);
         rd(rows[k][24:16], rows[k][7:0]);
      end
      // a mid-run reset clears every byte
      @(negedge mclk) rst = 1;
      @(negedge mclk) rst = 0;
      rd(9'h11d, 8'h00);
      rd(9'h123, 8'h00);
      // bypass with the far side stalled for 80 ns, well past the point where the skid entry fills
      fork #80 stall = 0; join_none
      for (int k = 0; k < 4; k++) send(14'h0100 + 14'(k) * 14'h1000);
      idle;
      for (int k = 0; k < 4; k++) begin
         pop(a, b);
         chk(a, 14'h0100 + 14'(k) * 14'h1000);
         chk(b, 14'h0000);
      end
      // zero phase: full cosine, no sine
      wr(9'h11d, 8'h01);
      send(14'h0100);
      idle;
      pop(a, b);
      chk(a, 14'd254);
      chk(b, 14'h0000);
      // quarter turn loads on restart; the later half turn waits for sync
      wr(9'h123, 8'h40);
      wr(9'h11d, 8'h00);
      wr(9'h11d, 8'h01);
      wr(9'h123, 8'h80);
      send(14'h0100);
      idle;
      sync_pin = 1;
      repeat (6) @(negedge mclk);
      sync_pin = 0;
      send(14'h0100);
      idle;
      pop(a, b);
      pop(c, d);
      chk(a, 14'h0000);
      chk(b, 14'h3f02);
      chk(c, 14'h3f02);
      chk(d, 14'h0000);
      // negative half-rate word: outputs alternate in sign
      wr(9'h123, 8'h00);
      wr(9'h121, 8'h80);
      wr(9'h11d, 8'h00);
      wr(9'h11d, 8'h01);
      send(14'h0100);
      send(14'h0100);
      idle;
      pop(a, b);
      pop(c, d);
      chk(a + c, 14'h0000);
      chk(a[13] ? c : a, 14'd254);
      // amplitude dither moves cosine by one step at most
      wr(9'h121, 8'h00);
      wr(9'h11d, 8'h00);
      wr(9'h11d, 8'h03);
      repeat (2) begin
         send(14'h0100);
         idle;
         pop(a, b);
         chk({13'h0, a == 14'd254 || a == 14'd256}, 14'h0001);
         chk(b, a == 14'd254 ? 14'h0000 : 14'h3ffe);
      end
      // phase just below a table step: dither carries it over, plain tuning does not
      wr(9'h122, 8'hff);
      wr(9'h123, 8'h07);
      wr(9'h11d, 8'h00);
      wr(9'h11d, 8'h01);
      send(14'h0100);
      idle;
      pop(a, b);
      chk(a, 14'h00fe);
      chk(b, 14'h0000);
      wr(9'h11d, 8'h00);
      wr(9'h11d, 8'h05);
      repeat (2) begin
         send(14'h0100);
         idle;
         pop(a, b);
         if (a == 14'h00fa) hits++;
         chk({13'h0, a == 14'h00fe || a == 14'h00fa}, 14'h0001);
         chk(b, a == 14'h00fe ? 14'h0000 : 14'h3fce);
      end
      chk({13'h0, hits > 0}, 14'h0001);
      final_report;
   end
endmodule // test_nco_tuning_control
